// ### logic/flash_seq_params.svh
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH
// control word bit positions
`define CTL_PULSE_BIT   0
`define CTL_LATCH_BIT   1
`define CTL_ERASE_BIT   2
`define CTL_VERIFY_BIT  3
// reset value of the control bits
`define CTL_RESET       4'h0
// erased cell value
`define ERASED_WORD     16'hFFFF
// program recovery time, in cycles
`define PROG_RECOVERY_CYC 3
`endif

// ### logic/flash_seq_pkg.sv
package flash_seq_pkg;
  // control bits as software writes them
  typedef struct packed {
    logic verify_select;
    logic erase_select;
    logic latch_enable;
    logic pulse_enable;
  } ctl_s;

  // one bus access to the module
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  be;
    logic [15:0] addr;
    logic [15:0] wdata;
  } acc_s;

  // operating mode of the array
  typedef enum logic [1:0] {
    MODE_READ = 2'b00,
    MODE_LATCHED = 2'b01,
    MODE_PROGRAM = 2'b10,
    MODE_ERASE = 2'b11
  } mode_e;
endpackage

// ### logic/flash_program_erase_sequencer.sv
`timescale 1ns/10ps
`include "flash_seq_params.svh"

module flash_program_erase_sequencer #(
  parameter int AW    = 16,
  parameter int DEPTH = 256,
  parameter int SHW   = 4
) (
  // clock and reset
  input  wire logic                  i_mclk,
  input  wire logic                  i_srst,
  // control bits from software
  input  wire logic                  i_ctl_we,
  input  wire flash_seq_pkg::ctl_s   i_ctl,
  // array access port, word addressed
  input  wire flash_seq_pkg::acc_s   i_acc,
  // answers and status
  output logic [15:0]                o_rdata,
  output logic                       o_rvalid,
  output flash_seq_pkg::ctl_s        o_ctl,
  output logic                       o_hv_program,
  output logic                       o_hv_erase,
  output logic [SHW-1:0]             o_shadow,
  output logic                       o_latched
);

  localparam int IW = $clog2(DEPTH);

  // ****************************************
  // state
  // ****************************************
  flash_seq_pkg::ctl_s ctl_q, ctl_d;
  logic [15:0]         mem_q [DEPTH];
  logic [15:0]         mem_wd;
  logic [IW-1:0]       mem_wa;
  logic                mem_we, mem_erase;
  logic [AW-1:0]       laddr_q, laddr_d;
  logic [15:0]         ldata_q, ldata_d;
  logic [1:0]          lbe_q, lbe_d;
  logic                latched_q, latched_d;
  logic                hv_prog_q, hv_prog_d;
  logic                hv_erase_q, hv_erase_d;
  logic [SHW-1:0]      shadow_q, shadow_d;
  logic [15:0]         rdata_q, rdata_d;
  logic                rvalid_q, rvalid_d;
  logic                shadow_hit;

  // shadow bits sit at the top address of the space
  assign shadow_hit = (i_acc.addr == {AW{1'b1}});

  // byte-lane mask of the latched word
  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction

  // ****************************************
  // control and latches
  // ****************************************
  always_comb begin
    ctl_d        = ctl_q;
    laddr_d      = laddr_q;
    ldata_d      = ldata_q;
    lbe_d        = lbe_q;
    latched_d    = latched_q;
    if (i_ctl_we) begin
      if (ctl_q.pulse_enable) begin
        // other bits frozen while the pulse runs
        ctl_d.pulse_enable = i_ctl.pulse_enable;
      end else begin
        ctl_d = i_ctl;
        // pulse allowed only after a latching write
        ctl_d.pulse_enable = i_ctl.pulse_enable & ctl_q.latch_enable
                             & latched_q & i_ctl.latch_enable;
      end
    end
    // leaving latch mode drops the latches
    if (!ctl_d.latch_enable) begin
      latched_d = 1'b0;
    end
    // only the first write after latch enable loads the latches; a write in the
    // cycle that clears latch enable is dropped so no latch outlives the mode
    if (i_acc.valid && i_acc.write && ctl_q.latch_enable && ctl_d.latch_enable
        && !latched_q && !ctl_q.pulse_enable) begin
      laddr_d   = i_acc.addr[AW-1:0];
      ldata_d   = i_acc.wdata;        // data unused in erase
      lbe_d     = i_acc.be;
      latched_d = 1'b1;
    end
    // voltage flags registered with the control bits so they leave a flop
    hv_prog_d  = ctl_d.pulse_enable & ~ctl_d.erase_select;
    hv_erase_d = ctl_d.pulse_enable & ctl_d.erase_select;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ctl_q        <= `CTL_RESET;
      laddr_q      <= '0;
      ldata_q      <= 16'h0000;
      lbe_q        <= 2'b00;
      latched_q    <= 1'b0;
      hv_prog_q    <= 1'b0;
      hv_erase_q   <= 1'b0;
    end else begin
      ctl_q        <= ctl_d;
      laddr_q      <= laddr_d;
      ldata_q      <= ldata_d;
      lbe_q        <= lbe_d;
      latched_q    <= latched_d;
      hv_prog_q    <= hv_prog_d;
      hv_erase_q   <= hv_erase_d;
    end
  end

  // ****************************************
  // array and shadow update on every cycle of the pulse
  // ****************************************
  always_comb begin
    mem_we    = 1'b0;
    mem_erase = 1'b0;
    mem_wa    = laddr_q[IW-1:0];
    mem_wd    = mem_q[laddr_q[IW-1:0]];
    shadow_d  = shadow_q;
    // a pulse acts on the cells while voltage is applied
    if (ctl_q.pulse_enable) begin
      if (ctl_q.erase_select) begin
        mem_erase = 1'b1;
        shadow_d  = {SHW{1'b1}};
      end else if (laddr_q == {AW{1'b1}}) begin
        // shadow bits program like array cells
        shadow_d = shadow_q & ldata_q[SHW-1:0];
      end else begin
        mem_we = 1'b1;
        // only ones may go to zero in the selected lanes
        mem_wd = mem_q[laddr_q[IW-1:0]] & (ldata_q | ~lane_mask(lbe_q));
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      shadow_q <= {SHW{1'b1}};
    end else begin
      shadow_q <= shadow_d;
    end
  end

  // array contents survive reset like real flash cells
  always_ff @(posedge i_mclk) begin
    if (mem_erase) begin
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= `ERASED_WORD;
    end else if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    // reads ignored while voltage is on
    if (i_acc.valid && !i_acc.write && !ctl_q.pulse_enable) begin
      rvalid_d = 1'b1;
      if (shadow_hit)
        rdata_d = {{(16-SHW){1'b1}}, shadow_q};
      else if (ctl_q.verify_select && ctl_q.latch_enable)
        rdata_d = (ldata_q ^ mem_q[i_acc.addr[IW-1:0]])
                  & lane_mask(lbe_q);
      else
        rdata_d = mem_q[i_acc.addr[IW-1:0]];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ****************************************
  // outputs, all registered
  // ****************************************
  assign o_rdata      = rdata_q;
  assign o_rvalid     = rvalid_q;
  assign o_ctl        = ctl_q;
  assign o_hv_program = hv_prog_q;
  assign o_hv_erase   = hv_erase_q;
  assign o_shadow     = shadow_q;
  assign o_latched    = latched_q;

  // ****************************************
  // checks
  // ****************************************
  property p_pulse_needs_latch;
    @(posedge i_mclk) disable iff (i_srst)
      $rose(ctl_q.pulse_enable) |-> $past(latched_q) && $past(ctl_q.latch_enable);
  endproperty
  a_pulse_needs_latch: assert property (p_pulse_needs_latch)
    else $error("pulse enable rose without a latched write");

  property p_frozen;
    @(posedge i_mclk) disable iff (i_srst)
      $past(ctl_q.pulse_enable) |->
        $stable({ctl_q.latch_enable, ctl_q.erase_select, ctl_q.verify_select});
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("control bits changed during a pulse");

  property p_no_read_in_pulse;
    @(posedge i_mclk) disable iff (i_srst)
      ctl_q.pulse_enable |=> !rvalid_q;
  endproperty
  a_no_read_in_pulse: assert property (p_no_read_in_pulse)
    else $error("read answered during a pulse");

  property p_latch_drop;
    @(posedge i_mclk) disable iff (i_srst)
      !ctl_q.latch_enable |-> !latched_q;
  endproperty
  a_latch_drop: assert property (p_latch_drop)
    else $error("latches held without latch enable");

  property p_erase_all;
    @(posedge i_mclk) disable iff (i_srst)
      o_hv_erase |=> shadow_q == {SHW{1'b1}} && mem_q[0] == `ERASED_WORD;
  endproperty
  a_erase_all: assert property (p_erase_all)
    else $error("erase left cells unerased");

  property p_prog_one_to_zero;
    @(posedge i_mclk) disable iff (i_srst)
      mem_we |=> (mem_q[$past(laddr_q[IW-1:0])]
                        & ~$past(mem_q[laddr_q[IW-1:0]])) == 16'h0000;
  endproperty
  a_prog_one_to_zero: assert property (p_prog_one_to_zero)
    else $error("programming raised a bit");

  property p_verify;
    @(posedge i_mclk) disable iff (i_srst)
      i_acc.valid && !i_acc.write && !shadow_hit && !ctl_q.pulse_enable
      && ctl_q.verify_select && ctl_q.latch_enable
      |=> rvalid_q && rdata_q == (($past(ldata_q) ^ $past(mem_q[i_acc.addr[IW-1:0]]))
                                   & lane_mask($past(lbe_q)));
  endproperty
  a_verify: assert property (p_verify)
    else $error("verify read wrong");

  property p_latch_once;
    @(posedge i_mclk) disable iff (i_srst)
      latched_q && ctl_q.latch_enable |=> $stable(laddr_q);
  endproperty
  a_latch_once: assert property (p_latch_once)
    else $error("second location latched");

  c_program: cover property (@(posedge i_mclk) disable iff (i_srst) o_hv_program);
  c_erase: cover property (@(posedge i_mclk) disable iff (i_srst) o_hv_erase);
  c_verify: cover property (@(posedge i_mclk) disable iff (i_srst)
    rvalid_q && ctl_q.verify_select && rdata_q == 16'h0000);
  c_shadow: cover property (@(posedge i_mclk) disable iff (i_srst)
    $fell(o_shadow[1]));

endmodule

// ### verification/host.sv
`timescale 1ns/10ps
// ************************************
// software host driving the control bits
// ************************************
module host #(
  parameter int ERASE_INC = 4,  // erase step in cycles, scaled down
  parameter int ERASE_REC = 2   // erase recovery in cycles, scaled
) (
  // clock
  input  wire logic           i_mclk,
  // requests toward the module
  output logic                o_ctl_we,
  output flash_seq_pkg::ctl_s o_ctl,
  output flash_seq_pkg::acc_s o_acc
);
  // idle bus at time zero; one host per module
  initial begin
    o_ctl_we = 1'b0;
    o_ctl    = 4'h0;
    o_acc    = '0;
  end
  // control write, strobe held for one edge
  task automatic ctl(input logic [3:0] v);
    @(posedge i_mclk);
    o_ctl_we <= 1'b1;
    o_ctl    <= v;
    @(posedge i_mclk);
    o_ctl_we <= 1'b0;
  endtask
  // one access; released lines show inverted junk, not the last value
  task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                     input logic [1:0] b);
    @(posedge i_mclk);
    o_acc <= {1'b1, w, b, a, d};
    @(posedge i_mclk);
    o_acc <= {1'b0, w, ~b, ~a, ~d};
  endtask
  // one pulse of n+2 cycles, then a recovery wait
  task automatic pulse(input logic [3:0] base, input int n, input int rec);
    ctl(base | 4'h1);
    repeat (n) @(posedge i_mclk);
    ctl(base);
    repeat (rec) @(posedge i_mclk);
  endtask
  // growing erase pulses, then one margin pulse of their summed length
  task automatic erase_seq(input int np);
    int sum;
    sum = 0;
    for (int k = 1; k <= np; k++) begin
      acc(1'b1, 16'(k), 16'($urandom), 2'b11);
      pulse(4'h6, k * ERASE_INC, ERASE_REC);
      sum += k * ERASE_INC;
    end
    pulse(4'h6, sum, ERASE_REC);
  endtask
endmodule

// ### verification/test_flash_program_erase_sequencer.sv
`timescale 1ns/10ps
// ************************************
// self-checking bench
// ************************************
module test_flash_program_erase_sequencer;
  logic                i_mclk;
  logic                i_srst;
  logic                ctl_we;
  flash_seq_pkg::ctl_s ctl;
  flash_seq_pkg::acc_s acc;
  logic [15:0]         rdata;
  logic                rvalid;
  flash_seq_pkg::ctl_s ctl_q;
  logic                hv_p;
  logic                hv_e;
  logic [3:0]          shadow;
  logic                latched;
  logic [15:0]         st;
  logic [15:0]         exp_mem [int];
  logic [15:0]         a;
  logic [15:0]         d;
  logic [15:0]         old;
  logic [1:0]          be;
  int                  errors = 0;
  int                  n_compared = 0;
  int                  cycles = 0;

  // status word: shadow, hv, latched, control
  assign st = {shadow, 1'b0, hv_p, hv_e, latched, 4'h0, ctl_q};

  flash_program_erase_sequencer flash_program_erase_sequencer_inst (
    .i_mclk       (i_mclk),
    .i_srst       (i_srst),
    .i_ctl_we     (ctl_we),
    .i_ctl        (ctl),
    .i_acc        (acc),
    .o_rdata      (rdata),
    .o_rvalid     (rvalid),
    .o_ctl        (ctl_q),
    .o_hv_program (hv_p),
    .o_hv_erase   (hv_e),
    .o_shadow     (shadow),
    .o_latched    (latched)
  );
  host host_inst (
    .i_mclk   (i_mclk),
    .o_ctl_we (ctl_we),
    .o_ctl    (ctl),
    .o_acc    (acc)
  );

  // clock and a hang guard well above the expected run length
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  // cell value after programming only clears bits in enabled lanes
  function automatic logic [15:0] mask(input logic [1:0] b);
    return {{8{b[1]}}, {8{b[0]}}};
  endfunction
  function automatic logic [15:0] mem(input logic [15:0] ad);
    return exp_mem.exists(ad) ? exp_mem[ad] : 16'hFFFF;
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read: answer is registered on the edge that takes the access
  task automatic rd(input logic [15:0] ad, input logic [15:0] exp);
    host_inst.acc(1'b0, ad, 16'h0000, 2'b11);
    #1;
    cmp({15'h0000, rvalid}, 16'h0001);
    cmp(rdata, exp);
  endtask
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    i_srst = 1'b1;
    void'($urandom(32'h3a62_d9e8));
    repeat (5) @(posedge i_mclk);
    i_srst <= 1'b0;
    // host settles one cycle before touching the array after leaving reset
    @(posedge i_mclk);
    #1 cmp(st, 16'hF000);
    $display("test reset done");
    // pulse refused without latch and latching write
    host_inst.ctl(4'h1);
    host_inst.ctl(4'h3);
    host_inst.ctl(4'h3);
    #1 cmp(st, 16'hF002);
    $display("test refusal done");
    // shadow bits through the array sequence
    host_inst.acc(1'b1, 16'hFFFF, 16'h0005, 2'b11);
    host_inst.pulse(4'h2, 3, 3);
    host_inst.ctl(4'h0);
    #1 cmp(st, 16'h5000);
    rd(16'hFFFF, 16'hFFF5);
    $display("test shadow done");
    // erase: voltage, frozen controls, ignored reads, whole array
    host_inst.ctl(4'h6);
    host_inst.acc(1'b1, 16'($urandom_range(0, 255)), 16'($urandom), 2'b11);
    host_inst.ctl(4'h7);
    #1 cmp({4'h0, st[11:0]}, 16'h0307);
    host_inst.ctl(4'h3);
    #1 cmp({4'h0, st[11:0]}, 16'h0307);
    host_inst.acc(1'b0, 16'h0000, 16'h0000, 2'b11);
    #1 cmp({15'h0000, rvalid}, 16'h0000);
    host_inst.ctl(4'h6);
    #1 cmp({4'h0, st[11:0]}, 16'h0106);
    host_inst.erase_seq(3);
    host_inst.ctl(4'h0);
    #1 cmp(st, 16'hF000);
    for (int k = 0; k < 4; k++) rd(16'($urandom_range(0, 255)), 16'hFFFF);
    $display("test erase done");
    // program random words and bytes, same address twice first
    for (int k = 0; k < 12; k++) begin
      a  = (k < 2) ? 16'h0010 : 16'($urandom_range(0, 255));
      d  = 16'($urandom);
      be = 2'($urandom_range(1, 3));
      old = mem(a);
      host_inst.ctl(4'h2);
      host_inst.acc(1'b1, a, d, be);
      host_inst.acc(1'b1, a ^ 16'h0001, ~d, 2'b11);
      host_inst.ctl(4'hA);
      rd(a, (d ^ old) & mask(be));
      host_inst.ctl(4'h3);
      #1 cmp({4'h0, st[11:0]}, 16'h0503);
      host_inst.ctl(4'h2);
      #1 cmp({4'h0, st[11:0]}, 16'h0102);
      host_inst.pulse(4'h2, 2, 3);
      exp_mem[a] = old & (d | ~mask(be));
      host_inst.ctl(4'hA);
      rd(a, (d ^ mem(a)) & mask(be));
      host_inst.ctl(4'h0);
      #1 cmp(st, 16'hF000);
      rd(a, mem(a));
      rd(a ^ 16'h0001, mem(a ^ 16'h0001));
    end
    $display("test program done");
    final_report();
  end
endmodule
